//--- include/moc_cfg.svh
`ifndef MOC_CFG_SVH
`define MOC_CFG_SVH

// Register indices; byte addresses are four times these
`define MOC_IDX_OPT_A        10'h01F
`define MOC_IDX_OPT_B        10'h020

// Option register A field positions
`define MOC_A_STANDBY        7
`define MOC_A_ROM_LOCK       6
`define MOC_A_LVI_RST_DIS    5
`define MOC_A_LVI_PWR_DIS    4
`define MOC_A_SHORT_WAKE     3
`define MOC_A_WDOG_RATE      2
`define MOC_A_STOP_EN        1
`define MOC_A_WDOG_DIS       0

// Option register B field positions
`define MOC_B_EE_PROTECT     0

// Hardwired option defaults, chosen at manufacture
`define MOC_OPT_A_DEFAULT    8'h02
`define MOC_OPT_B_DEFAULT    8'h00

// Protected EEPROM window
`define MOC_EE_PROT_LO       12'h8F0
`define MOC_EE_PROT_HI       12'h8FF

// Timing, in crystal clock cycles; ref_clk is the crystal clock
`define MOC_XTAL_PER_REF     1
`define MOC_WAKE_SHORT_XTAL  32
`define MOC_WAKE_LONG_XTAL   4096
`define MOC_WAKE_SHORT_CYC   (`MOC_WAKE_SHORT_XTAL * `MOC_XTAL_PER_REF)
`define MOC_WAKE_LONG_CYC    (`MOC_WAKE_LONG_XTAL * `MOC_XTAL_PER_REF)
`define MOC_WDOG_LONG_XTAL   ((1 << 18) - (1 << 4))
`define MOC_WDOG_SHORT_XTAL  ((1 << 13) - (1 << 4))
`define MOC_WDOG_LONG_CYC    (`MOC_WDOG_LONG_XTAL * `MOC_XTAL_PER_REF)
`define MOC_WDOG_SHORT_CYC   (`MOC_WDOG_SHORT_XTAL * `MOC_XTAL_PER_REF)

`endif

//--- include/moc_pkg.sv
package moc_pkg;
  typedef enum logic [1:0] {
    WAKE_IDLE  = 2'b01,
    WAKE_COUNT = 2'b10
  } moc_wake_e;

  typedef logic [7:0] moc_opt_t;
endpackage

//--- rtl/moc_wake_timer.sv
`timescale 1ns/100ps
`include "moc_cfg.svh"
module moc_wake_timer (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic shortSel,
  input  wire logic wakeReq,
  output logic      cpuResume
);
  moc_pkg::moc_wake_e state_r;
  logic [12:0]        cnt_r;
  logic [12:0]        limit;

  assign limit = shortSel ? 13'(`MOC_WAKE_SHORT_CYC - 1) : 13'(`MOC_WAKE_LONG_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= moc_pkg::WAKE_IDLE;
      cnt_r   <= 13'h0000;
    end else begin
      case (state_r)
        moc_pkg::WAKE_IDLE: begin
          cnt_r <= 13'h0000;
          if (wakeReq) begin
            state_r <= moc_pkg::WAKE_COUNT;
          end
        end
        moc_pkg::WAKE_COUNT: begin
          cnt_r <= cnt_r + 13'h0001;
          if (cnt_r == limit) begin
            state_r <= moc_pkg::WAKE_IDLE;
          end
        end
        default: begin
          state_r <= moc_pkg::WAKE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpuResume <= 1'b0;
    end else begin
      cpuResume <= (state_r == moc_pkg::WAKE_COUNT) && (cnt_r == limit);
    end
  end

  a_wake_short: assert property (@(posedge ref_clk) disable iff (rst)
    (wakeReq && shortSel && state_r == moc_pkg::WAKE_IDLE) |-> ##33 cpuResume)
    else $error("short wake delay not 32 cycles");
  a_wake_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (wakeReq && state_r == moc_pkg::WAKE_IDLE) |=> !cpuResume [*8])
    else $error("resume came too early");
endmodule

//--- rtl/moc_watchdog.sv
`timescale 1ns/100ps
`include "moc_cfg.svh"
module moc_watchdog #(
  parameter logic [17:0] LONG_CYC  = 18'(`MOC_WDOG_LONG_CYC),
  parameter logic [17:0] SHORT_CYC = 18'(`MOC_WDOG_SHORT_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic disable_wd,
  input  wire logic longSel,
  input  wire logic service,
  output logic      bite
);
  logic [17:0] cnt_r;
  logic [17:0] limit;

  assign limit = (longSel ? LONG_CYC : SHORT_CYC) - 18'h0_0001;

  always_ff @(posedge ref_clk) begin
    if (rst || disable_wd || service || cnt_r == limit) begin
      cnt_r <= 18'h0_0000;
    end else begin
      cnt_r <= cnt_r + 18'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bite <= 1'b0;
    end else begin
      bite <= !disable_wd && !service && (cnt_r == limit);
    end
  end

  a_wdog_bite: assert property (@(posedge ref_clk) disable iff (rst)
    (!disable_wd && !service && cnt_r == limit) |=> bite && cnt_r == 18'h0_0000)
    else $error("watchdog missed its timeout");
  a_wdog_held: assert property (@(posedge ref_clk) disable iff (rst)
    disable_wd |=> !bite && cnt_r == 18'h0_0000)
    else $error("disabled watchdog is running");
endmodule

//--- rtl/moc_option_bank.sv
`timescale 1ns/100ps
`include "moc_cfg.svh"
// What this block does
// - Option values are hardwired at manufacture; running device cannot alter them.
// - Standby bit 7 keeps detector running in stop; zero stops it.
// - ROM lock bit 6 set blocks ROM access; clear leaves access open.
// - Detector reset-disable bit 5 set suppresses detector resets.
// - Detector power-disable bit 4 set removes detector power.
// - Stop exit waits 32 cycles with short-wake set, else 4096.
// - Watchdog timeout 2^18-2^4 cycles with rate set, else 2^13-2^4.
// - Stop-enable set lets stop execute; clear makes it an illegal opcode.
// - Watchdog disable bit 0 set holds the watchdog off.
// - EEPROM protect set refuses program/erase of 8F0-8FF and config registers.
module moc_option_bank #(
  parameter moc_pkg::moc_opt_t OPT_A          = `MOC_OPT_A_DEFAULT,
  parameter moc_pkg::moc_opt_t OPT_B          = `MOC_OPT_B_DEFAULT,
  parameter logic [17:0]       WDOG_LONG_CYC  = 18'(`MOC_WDOG_LONG_CYC),
  parameter logic [17:0]       WDOG_SHORT_CYC = 18'(`MOC_WDOG_SHORT_CYC)
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        inStop,
  input  wire logic        lviTrip,
  input  wire logic        romReadReq,
  input  wire logic        stopOpcode,
  input  wire logic        eeWriteReq,
  input  wire logic [11:0] eeWriteAddr,
  input  wire logic        eeCfgSel,
  input  wire logic        stopWakeReq,
  input  wire logic        wdogService,
  output logic             lviPowerOn,
  output logic             lviActive,
  output logic             lviResetOut,
  output logic             romReadGrant,
  output logic             romReadBlocked,
  output logic             stopEnter,
  output logic             illegalOpcode,
  output logic             eeWriteGrant,
  output logic             eeWriteRefused,
  output logic             cpuResume,
  output logic             watchdogEnabled,
  output logic             watchdogReset
);

  function automatic logic [11:0] regAddr(input logic [9:0] idx);
    regAddr = {idx, 2'b00};
  endfunction

  function automatic logic hitAddr(input logic [11:0] a, input logic [9:0] idx);
    hitAddr = (a == regAddr(idx));
  endfunction

  // Hardwired option nets; no flop holds them, so reset cannot touch them
  moc_pkg::moc_opt_t optA;
  moc_pkg::moc_opt_t optB;
  assign optA = OPT_A;
  assign optB = OPT_B;

  logic standbyRun;
  logic romLock;
  logic lviRstDis;
  logic lviPwrDis;
  logic shortWake;
  logic wdogLong;
  logic stopEn;
  logic wdogDis;
  logic eeProtect;

  assign standbyRun = optA[`MOC_A_STANDBY];
  assign romLock    = optA[`MOC_A_ROM_LOCK];
  assign lviRstDis  = optA[`MOC_A_LVI_RST_DIS];
  assign lviPwrDis  = optA[`MOC_A_LVI_PWR_DIS];
  assign shortWake  = optA[`MOC_A_SHORT_WAKE];
  assign wdogLong   = optA[`MOC_A_WDOG_RATE];
  assign stopEn     = optA[`MOC_A_STOP_EN];
  assign wdogDis    = optA[`MOC_A_WDOG_DIS];
  assign eeProtect  = optB[`MOC_B_EE_PROTECT];

  // APB slave: no wait states, answer in the first access-phase cycle
  logic        setup;
  logic        hitA;
  logic        hitB;
  logic [31:0] prdata_nxt;

  assign setup = psel && !penable;
  assign hitA  = hitAddr(paddr, `MOC_IDX_OPT_A);
  assign hitB  = hitAddr(paddr, `MOC_IDX_OPT_B);

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (!pwrite && hitA) begin
      prdata_nxt = {24'h00_0000, optA};
    end else if (!pwrite && hitB) begin
      prdata_nxt = {24'h00_0000, optB};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hitA && !hitB;
      if (setup) begin
        prdata <= prdata_nxt;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Write data has no sink: the option bits are not storage
  logic unusedWdata;
  assign unusedWdata = ^pwdata;

  // Detector trip is analog; two flops before use
  logic tripMeta_r;
  logic tripSync_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tripMeta_r <= 1'b0;
      tripSync_r <= 1'b0;
    end else begin
      tripMeta_r <= lviTrip;
      tripSync_r <= tripMeta_r;
    end
  end

  logic lviActive_nxt;
  assign lviActive_nxt = !lviPwrDis && (!inStop || standbyRun);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lviPowerOn  <= 1'b0;
      lviActive   <= 1'b0;
      lviResetOut <= 1'b0;
    end else begin
      lviPowerOn  <= !lviPwrDis;
      lviActive   <= lviActive_nxt;
      lviResetOut <= tripSync_r && lviActive_nxt && !lviRstDis;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      romReadGrant   <= 1'b0;
      romReadBlocked <= 1'b0;
    end else begin
      romReadGrant   <= romReadReq && !romLock;
      romReadBlocked <= romReadReq && romLock;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stopEnter     <= 1'b0;
      illegalOpcode <= 1'b0;
    end else begin
      stopEnter     <= stopOpcode && stopEn;
      illegalOpcode <= stopOpcode && !stopEn;
    end
  end

  logic eeInWindow;
  logic eeDeny;
  assign eeInWindow = (eeWriteAddr >= `MOC_EE_PROT_LO) && (eeWriteAddr <= `MOC_EE_PROT_HI);
  assign eeDeny     = eeProtect && (eeInWindow || eeCfgSel);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eeWriteGrant   <= 1'b0;
      eeWriteRefused <= 1'b0;
    end else begin
      eeWriteGrant   <= eeWriteReq && !eeDeny;
      eeWriteRefused <= eeWriteReq && eeDeny;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdogEnabled <= 1'b0;
    end else begin
      watchdogEnabled <= !wdogDis;
    end
  end

  moc_wake_timer u_wake (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .shortSel  (shortWake),
    .wakeReq   (stopWakeReq),
    .cpuResume (cpuResume)
  );

  moc_watchdog #(
    .LONG_CYC  (WDOG_LONG_CYC),
    .SHORT_CYC (WDOG_SHORT_CYC)
  ) u_wdog (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .disable_wd (wdogDis),
    .longSel    (wdogLong),
    .service    (wdogService),
    .bite       (watchdogReset)
  );

  a_read_opt_a: assert property (@(posedge ref_clk) disable iff (rst)
    (setup && !pwrite && hitA) |=> pready && !pslverr && prdata == {24'h00_0000, OPT_A})
    else $error("option A read wrong");
  a_read_opt_b: assert property (@(posedge ref_clk) disable iff (rst)
    (setup && !pwrite && hitB) |=> pready && !pslverr && prdata == {24'h00_0000, OPT_B})
    else $error("option B read wrong");
  a_write_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (setup && pwrite && hitA) |=> ##2 (optA == OPT_A && watchdogEnabled == !OPT_A[0]))
    else $error("write changed an option");
  a_rom_lock: assert property (@(posedge ref_clk) disable iff (rst)
    romReadReq |=> (romReadGrant != romLock) && (romReadBlocked == romLock))
    else $error("rom lock gating wrong");
  a_lvi_reset: assert property (@(posedge ref_clk) disable iff (rst)
    lviResetOut |-> !lviRstDis && !lviPwrDis && $past(tripSync_r))
    else $error("detector reset leaked");
  a_lvi_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (inStop && !standbyRun) |=> !lviActive && !lviResetOut)
    else $error("detector active in stop");
  a_lvi_power: assert property (@(posedge ref_clk) disable iff (rst)
    lviActive |-> lviPowerOn && !lviPwrDis)
    else $error("detector active unpowered");
  a_stop_opcode: assert property (@(posedge ref_clk) disable iff (rst)
    stopOpcode |=> (stopEnter == stopEn) && (illegalOpcode == !stopEn))
    else $error("stop opcode handling wrong");
  a_ee_window: assert property (@(posedge ref_clk) disable iff (rst)
    (eeWriteReq && eeProtect && eeWriteAddr == `MOC_EE_PROT_HI) |=> eeWriteRefused && !eeWriteGrant)
    else $error("protected eeprom write granted");
  a_ee_outside: assert property (@(posedge ref_clk) disable iff (rst)
    (eeWriteReq && !eeCfgSel && eeWriteAddr == 12'h8EF) |=> eeWriteGrant)
    else $error("unprotected eeprom write refused");
  a_wdog_enable: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> (watchdogEnabled == !wdogDis) && (!wdogDis || !watchdogReset))
    else $error("watchdog enable wrong");

  c_read_a: cover property (@(posedge ref_clk) disable iff (rst)
    setup && !pwrite && hitA ##1 pready);
  c_unmapped: cover property (@(posedge ref_clk) disable iff (rst)
    pslverr);
  c_wake: cover property (@(posedge ref_clk) disable iff (rst)
    stopWakeReq ##[1:1000] cpuResume);
  c_ee_refuse: cover property (@(posedge ref_clk) disable iff (rst)
    eeWriteRefused);
endmodule

//--- verif/mask_option_config_tb_top.sv
`timescale 1ns/100ps
`include "moc_cfg.svh"
module mask_option_config_tb_top;
  localparam int         NI          = 3;
  // Instance 1 models a crystal system: short-wake left at zero
  localparam logic [7:0] OPT_A  [NI] = '{8'hFF, 8'h00, 8'h0C};
  localparam logic [7:0] OPT_B  [NI] = '{8'h01, 8'h00, 8'h01};
  localparam int         WD_LONG     = 40;
  localparam int         WD_SHORT    = 20;
  localparam logic [11:0] ADDR_A     = 12'(`MOC_IDX_OPT_A * 4);
  localparam logic [11:0] ADDR_B     = 12'(`MOC_IDX_OPT_B * 4);
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        inStop = 1'b0, lviTrip = 1'b0, romReadReq = 1'b0, stopOpcode = 1'b0;
  logic        eeWriteReq = 1'b0, eeCfgSel = 1'b0, stopWakeReq = 1'b0, wdogService = 1'b0;
  logic [11:0] eeWriteAddr = 12'h000;
  logic [31:0] prdata [NI];
  logic [NI-1:0] pready, pslverr, lviPowerOn, lviActive, lviResetOut, romReadGrant;
  logic [NI-1:0] romReadBlocked, stopEnter, illegalOpcode, eeWriteGrant, eeWriteRefused;
  logic [NI-1:0] cpuResume, watchdogEnabled, watchdogReset;
  logic [31:0] seed = 32'h0000_EDEE;
  int          errTotal = 0;
  int          nCompared = 0;

  for (genvar k = 0; k < NI; k++) begin : g_dut
    moc_option_bank #(.OPT_A(OPT_A[k]), .OPT_B(OPT_B[k]),
      .WDOG_LONG_CYC(18'(WD_LONG)), .WDOG_SHORT_CYC(18'(WD_SHORT))) i_moc_option_bank (
      .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata[k]), .pready(pready[k]),
      .pslverr(pslverr[k]), .inStop(inStop), .lviTrip(lviTrip), .romReadReq(romReadReq),
      .stopOpcode(stopOpcode), .eeWriteReq(eeWriteReq), .eeWriteAddr(eeWriteAddr),
      .eeCfgSel(eeCfgSel), .stopWakeReq(stopWakeReq), .wdogService(wdogService),
      .lviPowerOn(lviPowerOn[k]), .lviActive(lviActive[k]), .lviResetOut(lviResetOut[k]),
      .romReadGrant(romReadGrant[k]), .romReadBlocked(romReadBlocked[k]),
      .stopEnter(stopEnter[k]), .illegalOpcode(illegalOpcode[k]),
      .eeWriteGrant(eeWriteGrant[k]), .eeWriteRefused(eeWriteRefused[k]),
      .cpuResume(cpuResume[k]), .watchdogEnabled(watchdogEnabled[k]),
      .watchdogReset(watchdogReset[k]));
  end

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer, watched on instance k
  task automatic apb(input int k, input logic [11:0] a, input logic wr,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= rnd();
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready[k] !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata[k];
    err = pslverr[k];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    #300_000;
    errTotal++;
    giveVerdict();
  end

  initial begin
    logic [31:0] rd, r;
    logic        err, cfg, prot;
    logic [11:0] a;
    logic [7:0]  oa, ob;
    int          hit [NI];
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // Second pass follows a reset in mid-run
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < NI; k++) begin
        for (int j = 0; j < 6; j++) begin
          r = rnd();
          a = (j > 3) ? ({r[11:2], 2'b00} | 12'h100) : (j[0] ? ADDR_B : ADDR_A);
          apb(k, a, (j < 2) || (j == 5), rd, err);
          chk("pslverr", {31'h0, j > 3}, {31'h0, err});
          if (j == 2 || j == 3) chk("prdata", {24'h0, j[0] ? OPT_B[k] : OPT_A[k]}, rd);
        end
      end
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      inStop <= m[0];
      lviTrip <= m[1];
      repeat (6) @(posedge ref_clk);
      #1;
      for (int k = 0; k < NI; k++) begin
        oa = OPT_A[k];
        chk("lviPowerOn", {31'h0, !oa[4]}, {31'h0, lviPowerOn[k]});
        chk("lviActive", {31'h0, !oa[4] && (!m[0] || oa[7])}, {31'h0, lviActive[k]});
        chk("lviResetOut", {31'h0, m[1] && !oa[4] && (!m[0] || oa[7]) && !oa[5]},
            {31'h0, lviResetOut[k]});
        chk("watchdogEnabled", {31'h0, !oa[0]}, {31'h0, watchdogEnabled[k]});
      end
    end
    // Corners first, then random addresses, half of them inside the protected window
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      case (i)
        0: a = 12'h8EF;
        1: a = 12'h8F0;
        2: a = 12'h8FF;
        3: a = 12'h900;
        default: a = r[8] ? {8'h8F, r[3:0]} : r[19:8];
      endcase
      cfg = (i == 4) || (i > 4 && r[1]);
      @(posedge ref_clk);
      romReadReq <= 1'b1;
      stopOpcode <= 1'b1;
      eeWriteReq <= 1'b1;
      eeWriteAddr <= a;
      eeCfgSel <= cfg;
      @(posedge ref_clk);
      romReadReq <= 1'b0;
      stopOpcode <= 1'b0;
      eeWriteReq <= 1'b0;
      #1;
      for (int k = 0; k < NI; k++) begin
        oa = OPT_A[k];
        ob = OPT_B[k];
        prot = ob[0] && (cfg || (a >= 12'h8F0 && a <= 12'h8FF));
        chk("romReadBlocked", {31'h0, oa[6]}, {31'h0, romReadBlocked[k]});
        chk("romReadGrant", {31'h0, !oa[6]}, {31'h0, romReadGrant[k]});
        chk("stopEnter", {31'h0, oa[1]}, {31'h0, stopEnter[k]});
        chk("illegalOpcode", {31'h0, !oa[1]}, {31'h0, illegalOpcode[k]});
        chk("eeWriteRefused", {31'h0, prot}, {31'h0, eeWriteRefused[k]});
        chk("eeWriteGrant", {31'h0, !prot}, {31'h0, eeWriteGrant[k]});
      end
    end
    @(posedge ref_clk);
    stopWakeReq <= 1'b1;
    @(posedge ref_clk);
    stopWakeReq <= 1'b0;
    hit = '{default: 0};
    for (int i = 1; i <= 4200; i++) begin
      @(posedge ref_clk);
      #1;
      for (int k = 0; k < NI; k++) if (cpuResume[k] === 1'b1 && hit[k] == 0) hit[k] = i;
    end
    for (int k = 0; k < NI; k++) begin
      oa = OPT_A[k];
      chk("wake delay", oa[3] ? 32'd32 : 32'd4096, hit[k]);
    end
    // Random service gaps never exceed eight cycles
    hit = '{default: 0};
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      @(posedge ref_clk);
      wdogService <= (i % 8 == 0) || r[0];
      #1;
      for (int k = 0; k < NI; k++) if (i > 3 && watchdogReset[k] === 1'b1) hit[k]++;
    end
    for (int k = 0; k < NI; k++) chk("bites while serviced", 32'd0, hit[k]);
    @(posedge ref_clk);
    wdogService <= 1'b1;
    @(posedge ref_clk);
    wdogService <= 1'b0;
    hit = '{default: 0};
    for (int i = 1; i <= 60; i++) begin
      @(posedge ref_clk);
      #1;
      for (int k = 0; k < NI; k++) if (watchdogReset[k] === 1'b1 && hit[k] == 0) hit[k] = i;
    end
    for (int k = 0; k < NI; k++) begin
      oa = OPT_A[k];
      r = oa[2] ? WD_LONG : WD_SHORT;
      if (oa[0]) chk("bite when disabled", 32'd0, hit[k]);
      else chk("bite time", r, hit[k]);
    end
    giveVerdict();
  end
endmodule
